// File: vam_voltage_hold.sv
// voltage hold supervisor with wishbone registers and event interrupt
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module vam_voltage_hold #(
  parameter int P_STEP_CYC = vam_pkg::STEP_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // wishbone slave
  input wire vam_pkg::vam_wb_req_t i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // measurement front end and program cycle
  input wire logic i_cycle_tick,
  input wire logic i_hold_block,
  input wire vam_pkg::vam_meas_t i_meas,
  // reference to dependent stages
  output vam_pkg::vam_ref_t o_ref,
  output logic o_hold_active,
  output logic o_dep_block,
  output logic o_dep_clear,
  output vam_pkg::vam_trk_t o_trk_mode,
  output logic [3:0] o_trk_ref_ch,
  output logic o_irq
);
  vam_pkg::vam_state_t st_ff;
  vam_pkg::vam_state_t nxt_st;
  logic [5:0] v_low;
  logic [5:0] used;
  logic all_low;
  logic any_low;
  logic i_high;
  logic step;
  logic tick;
  logic act;
  logic expire;
  logic rel;
  logic wr;
  logic rd;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] stat;
  logic [5:0] old_f;
  logic [5:0] new_f;

  function automatic logic [31:0] vam_merge(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction : vam_merge

  assign used = st_ff.ctrl[vam_pkg::CB_USED +: 6];

  always_comb
  begin
    for (int k = 0; k < 6; k++)
    begin
      v_low[k] = i_meas.vmag[k] < st_ff.vthr;
    end
    all_low = ((v_low | ~used) == 6'h3f) && (used != 6'h00);
    any_low = (v_low & used) != 6'h00;
    i_high = (i_meas.iamp[0] > st_ff.ithr) || (i_meas.iamp[1] > st_ff.ithr) ||
             (i_meas.iamp[2] > st_ff.ithr);
  end

  assign step = st_ff.pre == 21'(P_STEP_CYC - 1);
  assign tick = i_cycle_tick;

  // register read mux
  always_comb
  begin
    // status is live state, not sticky; only the event register remembers
    stat = 32'h0000_0000;
    stat[vam_pkg::SB_HOLD] = st_ff.hold;
    stat[vam_pkg::SB_LOWV] = st_ff.lowv;
    stat[vam_pkg::SB_IHIGH] = st_ff.ihigh;
    stat[vam_pkg::SB_CTRK] = st_ff.ctrk;
    stat[vam_pkg::SB_BLK] = st_ff.blk;
    stat[vam_pkg::SB_EXP] = st_ff.expd;
    stat[vam_pkg::SB_HEALTHY] = st_ff.hcnt > 10'(vam_pkg::HEALTHY_STEPS);
    case (i_wb.adr)
      vam_pkg::REG_CTRL: rdat = {21'h000000, st_ff.ctrl};
      vam_pkg::REG_VTHR: rdat = {16'h0000, st_ff.vthr};
      vam_pkg::REG_ITHR: rdat = {16'h0000, st_ff.ithr};
      vam_pkg::REG_TMAX: rdat = {18'h00000, st_ff.tmax};
      vam_pkg::REG_STAT: rdat = stat;
      vam_pkg::REG_EVT: rdat = {20'h00000, st_ff.evt};
      vam_pkg::REG_MASK: rdat = {20'h00000, st_ff.mask};
      default: rdat = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    act = 1'b0;
    expire = 1'b0;
    rel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wdat = 32'h0000_0000;
    // flags before and after this cycle; each one owns an on/off event pair
    old_f = {st_ff.blk, st_ff.hold, st_ff.ctrk, st_ff.ihigh, st_ff.lowv,
             st_ff.ctrl[vam_pkg::CB_EN]};
    new_f = old_f;
    if (i_ce)
    begin
      // wishbone: one wait state, ack drops the cycle after it is given
      nxt_st.ack = i_wb.cyc && i_wb.stb && !st_ff.ack;
      wr = nxt_st.ack && i_wb.we;
      rd = nxt_st.ack && !i_wb.we;
      if (rd)
      begin
        nxt_st.dat = rdat;
      end
      if (wr)
      begin
        case (i_wb.adr)
          vam_pkg::REG_CTRL:
          begin
            wdat = vam_merge({21'h000000, st_ff.ctrl}, i_wb.dat, i_wb.sel);
            nxt_st.ctrl = wdat[vam_pkg::CTRL_W-1:0];
          end
          vam_pkg::REG_VTHR:
          begin
            wdat = vam_merge({16'h0000, st_ff.vthr}, i_wb.dat, i_wb.sel);
            nxt_st.vthr = wdat[15:0];
          end
          vam_pkg::REG_ITHR:
          begin
            wdat = vam_merge({16'h0000, st_ff.ithr}, i_wb.dat, i_wb.sel);
            nxt_st.ithr = wdat[15:0];
          end
          vam_pkg::REG_TMAX:
          begin
            wdat = vam_merge({18'h00000, st_ff.tmax}, i_wb.dat, i_wb.sel);
            nxt_st.tmax = wdat[13:0];
          end
          vam_pkg::REG_MASK:
          begin
            wdat = vam_merge({20'h00000, st_ff.mask}, i_wb.dat, i_wb.sel);
            nxt_st.mask = wdat[vam_pkg::EVT_W-1:0];
          end
          default:
          begin
            wdat = 32'h0000_0000;
          end
        endcase
      end
      // a read of the event register clears it; new events below still land
      if (rd && i_wb.adr == vam_pkg::REG_EVT)
      begin
        nxt_st.evt = '0;
      end

      // 5 ms timebase for the healthy and hold timers
      nxt_st.pre = step ? 21'h000000 : st_ff.pre + 21'h000001;
      if (step)
      begin
        if (!any_low && st_ff.hcnt <= 10'(vam_pkg::HEALTHY_STEPS))
        begin
          nxt_st.hcnt = st_ff.hcnt + 10'h001;
        end
        if (st_ff.hold && st_ff.acnt != 14'h3fff)
        begin
          nxt_st.acnt = st_ff.acnt + 14'h0001;
        end
      end

      nxt_st.clr = 1'b0;
      if (tick)
      begin
        nxt_st.blk = i_hold_block;
        nxt_st.lowv = all_low;
        nxt_st.ihigh = st_ff.ctrl[vam_pkg::CB_ICOND] && i_high;
        nxt_st.ctrk = st_ff.ctrl[vam_pkg::CB_FCT] && all_low;
        // healthy history is judged before the drop clears the counter
        act = !st_ff.hold && !st_ff.expd && st_ff.ctrl[vam_pkg::CB_EN] &&
              !i_hold_block && all_low &&
              (st_ff.hcnt > 10'(vam_pkg::HEALTHY_STEPS)) &&
              (!st_ff.ctrl[vam_pkg::CB_ICOND] || i_high);
        expire = st_ff.hold && (st_ff.acnt >= st_ff.tmax);
        // release at the next program cycle tick when a used voltage returns, the enable drops or a block arrives
        rel = st_ff.hold && (!all_low || !st_ff.ctrl[vam_pkg::CB_EN] || i_hold_block);
        if (any_low)
        begin
          nxt_st.hcnt = 10'h000;
        end
        if (act)
        begin
          nxt_st.hold = 1'b1;
          nxt_st.acnt = 14'h0000;
        end
        else if (expire)
        begin
          nxt_st.hold = 1'b0;
          nxt_st.expd = 1'b1;
          nxt_st.clr = 1'b1;
        end
        else if (rel)
        begin
          nxt_st.hold = 1'b0;
        end
        // expiry blocks the dependent stage until voltages are back
        if (!all_low)
        begin
          nxt_st.expd = 1'b0;
        end
        if (!st_ff.hold && !act)
        begin
          nxt_st.ang_mem = i_meas.vang;
        end
      end
      // dropping the forced tracking enable takes effect at once, not at the next tick
      if (!nxt_st.ctrl[vam_pkg::CB_FCT])
      begin
        nxt_st.ctrk = 1'b0;
      end

      // substituted reference towards dependent stages
      for (int k = 0; k < 6; k++)
      begin
        nxt_st.out.mag[k] = nxt_st.hold ? nxt_st.vthr : i_meas.vmag[k];
        nxt_st.out.ang[k] = nxt_st.hold ? nxt_st.ang_mem[k] : i_meas.vang[k];
      end

      new_f = {nxt_st.blk, nxt_st.hold, nxt_st.ctrk, nxt_st.ihigh, nxt_st.lowv,
               nxt_st.ctrl[vam_pkg::CB_EN]};
      for (int k = 0; k < vam_pkg::EV_PAIRS; k++)
      begin
        nxt_st.evt[2*k] = nxt_st.evt[2*k] | (new_f[k] & ~old_f[k]);
        nxt_st.evt[2*k+1] = nxt_st.evt[2*k+1] | (~new_f[k] & old_f[k]);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.ctrl <= vam_pkg::CTRL_RST;
      st_ff.vthr <= vam_pkg::VTHR_RST;
      st_ff.ithr <= vam_pkg::ITHR_RST;
      st_ff.tmax <= vam_pkg::TMAX_RST;
      st_ff.mask <= vam_pkg::MASK_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_wb_ack = st_ff.ack;
  assign o_wb_dat = st_ff.dat;
  assign o_ref = st_ff.out;
  assign o_hold_active = st_ff.hold;
  assign o_dep_block = st_ff.expd;
  assign o_dep_clear = st_ff.clr;
  assign o_trk_ref_ch = vam_pkg::TRK_REF_CH;
  // level interrupt with no memory of its own: reading the event register drops it
  assign o_irq = (st_ff.evt & st_ff.mask) != '0;

  // frequency protection keeps its own tracking; this selects stage sampling only
  always_comb
  begin
    if (st_ff.ctrk)
    begin
      o_trk_mode = vam_pkg::TRK_CT_REF;
    end
    else if (st_ff.ctrl[vam_pkg::CB_FIXED])
    begin
      o_trk_mode = st_ff.ctrl[vam_pkg::CB_F60] ? vam_pkg::TRK_FIX60 : vam_pkg::TRK_FIX50;
    end
    else
    begin
      o_trk_mode = vam_pkg::TRK_VOLT;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  // entry conditions, held reference, blocking, expiry clear and tracking

  a_hold_healthy_first: assert property ($rose(st_ff.hold) |->
    $past(st_ff.hcnt) > 10'(vam_pkg::HEALTHY_STEPS))
    else $error("hold rose without healthy history");
  a_hold_low_volt: assert property ($rose(st_ff.hold) |-> st_ff.lowv)
    else $error("hold rose while voltage not low");
  a_hold_cur_cond: assert property ($rose(st_ff.hold) && $past(st_ff.ctrl[vam_pkg::CB_ICOND])
    |-> st_ff.ihigh)
    else $error("hold rose without current condition");
  a_mag_subst: assert property (st_ff.hold |->
    o_ref.mag[0] == st_ff.vthr && o_ref.mag[5] == st_ff.vthr)
    else $error("held magnitude differs from threshold");
  a_angle_frozen: assert property ($past(st_ff.hold) && st_ff.hold |->
    st_ff.ang_mem == $past(st_ff.ang_mem))
    else $error("latched angle moved during hold");
  a_block_sampled: assert property (i_ce && tick |=> st_ff.blk == $past(i_hold_block))
    else $error("block input not sampled at cycle start");
  a_block_no_hold: assert property (st_ff.blk |-> !st_ff.hold)
    else $error("hold active while blocked");
  a_expiry_clear: assert property ($rose(st_ff.expd) |-> st_ff.clr && !st_ff.hold
    ##1 !st_ff.clr || !i_ce)
    else $error("expiry without clear pulse");
  a_disabled_idle: assert property (!st_ff.ctrl[vam_pkg::CB_EN] |=> !$rose(st_ff.hold))
    else $error("hold activated while disabled");
  a_ct_tracking: assert property (o_trk_mode == vam_pkg::TRK_CT_REF |->
    st_ff.ctrl[vam_pkg::CB_FCT] && st_ff.lowv)
    else $error("current tracking without cause");
  a_ct_off_disabled: assert property (!st_ff.ctrl[vam_pkg::CB_FCT] |->
    o_trk_mode != vam_pkg::TRK_CT_REF)
    else $error("current tracking while forced tracking off");

  // hold exit and the substituted reference
  a_block_release: assert property (i_ce && tick && i_hold_block |=> !st_ff.hold)
    else $error("hold survived a blocked cycle");
  a_expired_idle: assert property (st_ff.expd |-> !st_ff.hold)
    else $error("hold active after expiry");
  a_angle_latch: assert property (i_ce && tick && !st_ff.hold |=>
    st_ff.hold || st_ff.ang_mem == $past(i_meas.vang))
    else $error("angle memory not refreshed while inactive");
  a_angle_subst: assert property (st_ff.hold |-> o_ref.ang == st_ff.ang_mem)
    else $error("held angle differs from latched angle");

  // events and single-cycle outputs
  a_event_hold_on: assert property ($rose(st_ff.hold) |-> st_ff.evt[8])
    else $error("hold on event missing");
  a_event_low_on: assert property ($rose(st_ff.lowv) |-> st_ff.evt[2])
    else $error("low voltage event missing");
  a_event_en_off: assert property ($fell(st_ff.ctrl[vam_pkg::CB_EN]) |-> st_ff.evt[1])
    else $error("disable event missing");
  a_ack_single: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
    else $error("bus ack longer than one cycle");
  a_clear_single: assert property (o_dep_clear && i_ce |=> !o_dep_clear)
    else $error("dependent clear longer than one cycle");

  c_hold_on: cover property ($rose(st_ff.hold));
  c_hold_expiry: cover property ($rose(st_ff.expd));
  c_hold_blocked: cover property ($fell(st_ff.hold) && st_ff.blk);
  c_irq_raise: cover property ($rose(o_irq));
  c_ct_track: cover property ($rose(st_ff.ctrk));
endmodule : vam_voltage_hold

// File: vam_pkg.sv
// constants and carrier types of the voltage hold supervisor
package vam_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VTHR = 8'h04;
  localparam logic [7:0] REG_ITHR = 8'h08;
  localparam logic [7:0] REG_TMAX = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_EVT = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  // control field positions
  localparam int CTRL_W = 11;
  localparam int CB_EN = 0;
  localparam int CB_ICOND = 1;
  localparam int CB_FCT = 2;
  localparam int CB_FIXED = 3;
  localparam int CB_F60 = 4;
  localparam int CB_USED = 5;
  // status field positions
  localparam int SB_HOLD = 0;
  localparam int SB_LOWV = 1;
  localparam int SB_IHIGH = 2;
  localparam int SB_CTRK = 3;
  localparam int SB_BLK = 4;
  localparam int SB_EXP = 5;
  localparam int SB_HEALTHY = 6;
  // event pairs: bit 2k is on, bit 2k+1 is off
  localparam int EVT_W = 12;
  localparam int EV_PAIRS = 6;
  // reset values: threshold in 0.01 %Un, current in 0.01 xIn, time in 5 ms steps
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h7e1;
  localparam logic [15:0] VTHR_RST = 16'h05dc;
  localparam logic [15:0] ITHR_RST = 16'h0064;
  localparam logic [13:0] TMAX_RST = 14'h0bb8;
  localparam logic [EVT_W-1:0] MASK_RST = 12'h000;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_TIME_US = 5000;
  localparam int STEP_CYC = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int HEALTHY_TIME_MS = 2500;
  localparam int HEALTHY_STEPS = (HEALTHY_TIME_MS * 1000) / STEP_TIME_US;
  localparam logic [3:0] TRK_REF_CH = 4'h3;

  typedef enum logic [1:0] {
    TRK_VOLT = 2'b00,
    TRK_FIX50 = 2'b01,
    TRK_FIX60 = 2'b10,
    TRK_CT_REF = 2'b11
  } vam_trk_t;

  typedef struct packed {
    logic [5:0][15:0] vmag;
    logic [5:0][15:0] vang;
    logic [2:0][15:0] iamp;
  } vam_meas_t;

  typedef struct packed {
    logic [5:0][15:0] mag;
    logic [5:0][15:0] ang;
  } vam_ref_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } vam_wb_req_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] vthr;
    logic [15:0] ithr;
    logic [13:0] tmax;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic [20:0] pre;
    logic [9:0] hcnt;
    logic [13:0] acnt;
    logic blk;
    logic lowv;
    logic ihigh;
    logic ctrk;
    logic hold;
    logic expd;
    logic clr;
    logic [5:0][15:0] ang_mem;
    vam_ref_t out;
    logic ack;
    logic [31:0] dat;
  } vam_state_t;
endpackage : vam_pkg

// File: vam_front_end.sv
// measurement front end model: program cycle ticks and phase quantities
`timescale 1ns/10ps
module vam_front_end #(
  parameter int P_STEP = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // scenario knobs
  input wire logic i_low,
  input wire logic i_ihigh,
  input wire logic [31:0] i_rnd,
  // toward the block
  output logic o_tick,
  output vam_pkg::vam_meas_t o_meas
);
  int cnt;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 0;
      o_tick <= 1'b0;
      o_meas <= '0;
    end
    else
    begin
      cnt <= (cnt + 1) % P_STEP;
      o_tick <= (cnt == 0);
      if (o_tick)
      begin
        for (int k = 0; k < 6; k++)
        begin
          o_meas.vmag[k] <= i_low ? 16'h0064 : 16'h2710 + 16'(i_rnd[k*4 +: 4]);
          // first collapsed cycle keeps the healthy angle, later ones are noise
          if (!i_low || o_meas.vmag[0] == 16'h0064)
            o_meas.vang[k] <= 16'(i_rnd[15:0] % 16'd35990) + 16'(k);
        end
        for (int k = 0; k < 3; k++)
          o_meas.iamp[k] <= i_ihigh ? 16'h00c8 : 16'h0032;
      end
    end
  end
endmodule : vam_front_end

// File: vam_voltage_hold_tb.sv
// self-checking bench of the voltage hold supervisor
`timescale 1ns/10ps
module vam_voltage_hold_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic low = 1'b0;
  logic ihigh = 1'b0;
  logic i_hold_block = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rnd = 32'hec08829c;
  vam_pkg::vam_wb_req_t i_wb = '0;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic tick;
  vam_pkg::vam_meas_t meas;
  vam_pkg::vam_ref_t o_ref;
  logic o_hold_active;
  logic o_dep_block;
  logic o_dep_clear;
  logic o_irq;
  vam_pkg::vam_trk_t o_trk_mode;
  logic [3:0] o_trk_ref_ch;
  logic [31:0] rd;
  logic [5:0][15:0] exp_ang;
  int clr_n = 0;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] radr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c};
  logic [31:0] rexp [6] = '{32'h7e1, 32'h5dc, 32'h64, 32'hbb8, 32'h0, 32'h0};

  always #2 i_clk_sys = ~i_clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  always @(posedge i_clk_sys) rnd <= lfsr(rnd);
  always @(posedge i_clk_sys) if (o_dep_clear === 1'b1) clr_n++;

  vam_front_end #(.P_STEP(4)) fe (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_low(low),
    .i_ihigh(ihigh), .i_rnd(rnd), .o_tick(tick), .o_meas(meas));

  vam_voltage_hold #(.P_STEP_CYC(4)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_ce(ce), .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .i_cycle_tick(tick), .i_hold_block(i_hold_block), .i_meas(meas), .o_ref(o_ref),
    .o_hold_active(o_hold_active), .o_dep_block(o_dep_block), .o_dep_clear(o_dep_clear),
    .o_trk_mode(o_trk_mode), .o_trk_ref_ch(o_trk_ref_ch), .o_irq(o_irq));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    @(posedge i_clk_sys);
    while (o_wb_ack !== 1'b1 && n < 50)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    chk("bus ack", 1, o_wb_ack);
    rd = o_wb_dat;
    i_wb <= '0;
  endtask : wb

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] m);
    wb(1'b0, adr, 32'h0);
    chk($sformatf("reg %h", adr), exp, rd & m);
  endtask : rdchk

  // waits n program cycles, then lets the registered answer settle
  task automatic ticks(input int n);
    repeat (n) @(posedge tick);
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask : ticks

  task automatic healthy();
    @(posedge i_clk_sys);
    low <= 1'b0;
    ticks(505);
  endtask : healthy

  task automatic drop();
    @(posedge i_clk_sys);
    low <= 1'b1;
    exp_ang = meas.vang;
    ticks(3);
  endtask : drop

  task automatic results();
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    #200000;
    bad_count++;
    results();
  end

  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    wb(1'b1, 8'h1c, 32'hffffffff);
    foreach (radr[i]) rdchk(radr[i], rexp[i], 32'hffffffff);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, vam_pkg::REG_CTRL, 32'h7e1 | (i == 0 ? 32'h0 : i == 1 ? 32'h8 : 32'h18));
      @(posedge i_clk_sys);
      chk("trk mode", 32'(i), {30'h0, o_trk_mode});
    end
    // activation with the current condition met, short time limit
    wb(1'b1, vam_pkg::REG_CTRL, 32'h7e3);
    wb(1'b1, vam_pkg::REG_TMAX, 32'h3);
    wb(1'b1, vam_pkg::REG_MASK, 32'h104);
    // clear the events left over from reset so the interrupt check means something
    wb(1'b0, vam_pkg::REG_EVT, 32'h0);
    ihigh <= 1'b1;
    healthy();
    drop();
    chk("hold", 1, o_hold_active);
    chk("irq", 1, o_irq);
    for (int k = 0; k < 6; k++)
    begin
      chk("ref mag", 32'h5dc, {16'h0, o_ref.mag[k]});
      chk("ref ang", {16'h0, exp_ang[k]}, {16'h0, o_ref.ang[k]});
    end
    // clock enable low freezes the hold timer; expiry would otherwise fall in this gap
    @(posedge i_clk_sys);
    ce <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    chk("ce freeze", 1, o_hold_active);
    chk("ce freeze mag", 32'h5dc, {16'h0, o_ref.mag[0]});
    ce <= 1'b1;
    rdchk(vam_pkg::REG_STAT, 32'h7, 32'h7);
    rdchk(vam_pkg::REG_EVT, 32'h104, 32'h104);
    @(posedge i_clk_sys);
    chk("irq clear", 0, o_irq);
    ticks(6);
    chk("hold end", 0, o_hold_active);
    chk("dep block", 1, o_dep_block);
    chk("dep clear", 1, clr_n);
    low <= 1'b0;
    ticks(10);
    drop();
    chk("short healthy", 0, o_hold_active);
    // blocking input holds activation off
    healthy();
    @(posedge i_clk_sys);
    i_hold_block <= 1'b1;
    drop();
    chk("blocked hold", 0, o_hold_active);
    rdchk(vam_pkg::REG_STAT, 32'h10, 32'h11);
    @(posedge i_clk_sys);
    i_hold_block <= 1'b0;
    ticks(2);
    rdchk(vam_pkg::REG_STAT, 32'h0, 32'h11);
    rdchk(vam_pkg::REG_EVT, 32'hc00, 32'hc00);
    // current condition unmet, forced current tracking on
    wb(1'b1, vam_pkg::REG_CTRL, 32'h7e7);
    ihigh <= 1'b0;
    healthy();
    drop();
    chk("no current", 0, o_hold_active);
    chk("trk forced", 32'h3, {30'h0, o_trk_mode});
    chk("trk chan", 32'h3, {28'h0, o_trk_ref_ch});
    rdchk(vam_pkg::REG_STAT, 32'h8, 32'hc);
    // function disabled never holds
    wb(1'b1, vam_pkg::REG_CTRL, 32'h7e2);
    rdchk(vam_pkg::REG_EVT, 32'h2, 32'h2);
    ihigh <= 1'b1;
    healthy();
    drop();
    chk("disabled", 0, o_hold_active);
    results();
  end
endmodule : vam_voltage_hold_tb
